/* File: usbep_map.svh */
/*
  Register offset, bit positions, reset values and sizing constants of the
  endpoint 4 control/status block. Assumes a plain word-addressed register port.
*/
`ifndef USBEP_MAP_SVH
`define USBEP_MAP_SVH

`define EP_ADDR_W 8
`define EP_CSR_OFF 8'h00
`define EP_MAX_PACKET_SIZE_FIELD_LSB 0
`define EP_MAX_PACKET_SIZE_FIELD_MSB 3
`define EP_MAX_PACKET_SIZE_FIELD_SET 7
`define EP_OUT_ISO 8
`define EP_OUT_AUTO 9
`define EP_DIR_IN 10
`define EP_IN_ISO 11
`define EP_IN_AUTO 12
`define EP_CFG_SET 15
`define EP_OUT_RDY 16
`define EP_OUT_SDSTALL 21
`define EP_OUT_STSTALL 22
`define EP_OUT_CLTOG 23
`define EP_IN_RDY 24
`define EP_IN_NEMP 25
`define EP_IN_UNDER 26
`define EP_IN_FLUSH 27
`define EP_IN_SDSTALL 28
`define EP_IN_STSTALL 29
`define EP_IN_CLTOG 30
`define EP_CFG_RESET 5'h04
`define EP_MAX_PACKET_SIZE_FIELD_RESET 4'h0
`define EP_FIFO_BYTES 8'h40
`define EP_MAX_PACKET_SIZE_FIELD_UNIT_SH 3

`endif

/* File: usbep_pkg.sv */
/*
  Types shared by the endpoint 4 control block and its helpers.
  Assumes the map header supplies every number.
*/
package usbep_pkg;
  typedef logic [1:0] usbep_cnt_t;
  typedef enum logic [1:0] {
    FL_IDLE = 2'b01,
    FL_WAIT = 2'b10
  } usbep_flush_e;
endpackage

/* File: usbep_in_if.sv */
/*
  Interface between the control block and the IN packet tracker.
  Assumes both ends share i_clk.
*/
`timescale 1ns/1ps
interface usbep_in_if;
  logic push;
  logic pop;
  logic clr;
  logic big;
  usbep_pkg::usbep_cnt_t cnt;
  logic full;
  modport ctl (output push, output pop, output clr, output big, input cnt, input full);
  modport trk (input push, input pop, input clr, input big, output cnt, output full);
endinterface

/* File: usbep_in_track.sv */
/*
  Counts packets held in the IN FIFO (0..2) and flags when it can take no more.
  Assumes push is never given while full and pop never while empty.
*/
`timescale 1ns/1ps
module usbep_in_track (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, low
  usbep_in_if.trk trk // tracker side
);
  usbep_pkg::usbep_cnt_t cnt_reg;

  // clear wins: an IN stall drops every count; a flush pops only one packet
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 2'h0;
    end else if (trk.clr) begin
      cnt_reg <= 2'h0;
    end else if (trk.push && !trk.pop) begin
      cnt_reg <= cnt_reg + 2'h1;
    end else if (trk.pop && !trk.push && cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end

  // a packet larger than half the FIFO fills it alone
  assign trk.cnt = cnt_reg;
  assign trk.full = trk.big ? (cnt_reg != 2'h0) : (cnt_reg == 2'h2);
endmodule

/* File: usbep_toggle.sv */
/*
  Data toggle bit of the endpoint: flips on each good non-iso transaction.
  Assumes clear and advance are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module usbep_toggle (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, low
  input wire logic i_clear, // force DATA0
  input wire logic i_advance, // transaction completed
  output logic o_toggle // 0 = DATA0, 1 = DATA1
);
  // clear wins so software can always resynchronise
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_toggle <= 1'b0;
    end else if (i_clear) begin
      o_toggle <= 1'b0;
    end else if (i_advance) begin
      o_toggle <= ~o_toggle;
    end
  end
endmodule

/* File: usbep_ep4_csr.sv */
/*
  Endpoint 4 control/status register and its handshake logic: packet size,
  direction, type, stall, toggle clear, IN packet ready, flush and underrun.
  Assumes a serial engine on the same clock that reports tokens as one-cycle
  pulses, and a FIFO data path outside that obeys the flush, drop and block
  signals driven here.
*/
`timescale 1ns/1ps
`include "usbep_map.svh"

module usbep_ep4_csr (
  input wire logic i_clk, // 10 MHz system clock
  input wire logic i_rstn, // async reset, low
  input wire logic [`EP_ADDR_W-1:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic i_out_tok, // OUT data packet received, pulse
  input wire logic [7:0] i_out_cnt, // bytes in that packet
  input wire logic i_out_unloaded, // software read last FIFO byte
  input wire logic i_in_tok, // IN token received, pulse
  input wire logic i_in_ack, // host acked IN data, pulse
  input wire logic i_xact_busy, // token transaction in progress
  output logic o_stall, // send STALL handshake, pulse
  output logic o_ack, // send ACK to OUT data, pulse
  output logic o_nak, // send NAK, pulse
  output logic o_in_send, // send oldest IN packet, pulse
  output logic o_in_zlp, // send zero-length packet, pulse
  output logic o_toggle, // data toggle, 0 = DATA0
  output logic o_fifo_flush, // drop oldest IN packet, pulse
  output logic o_fifo_drop, // discard packet just loaded, pulse
  output logic o_wr_block, // block software FIFO writes
  output logic o_int // interrupt pulse to processor
);
  logic [3:0] max_packet_size_field_reg;
  logic [4:0] cfg_reg;
  logic out_rdy_reg;
  logic out_sdstall_reg;
  logic out_ststall_reg;
  logic in_under_reg;
  logic in_flush_reg;
  logic in_sdstall_reg;
  logic in_ststall_reg;
  logic drop_next_reg;
  usbep_pkg::usbep_flush_e fl_state_reg;
  usbep_pkg::usbep_flush_e fl_state_next;
  logic wr_csr;
  logic rd_csr;
  logic dir_in;
  logic out_iso;
  logic in_iso;
  logic [7:0] max_packet_size_field_bytes;
  logic in_stall_ev;
  logic out_stall_ev;
  logic out_store;
  logic in_send_ev;
  logic under_ev;
  logic sw_set_rdy;
  logic flush_go;
  logic tog_clear;
  logic tog_adv;
  logic out_nak_ev;
  logic in_nak_ev;
  logic wr_block_next;
  logic [31:0] csr_word;
  usbep_in_if in_bus ();

  // decode of the single control/status word
  assign wr_csr = i_wr && (i_addr == `EP_CSR_OFF);
  assign rd_csr = i_rd && (i_addr == `EP_CSR_OFF);
  assign dir_in = cfg_reg[`EP_DIR_IN-`EP_OUT_ISO];
  assign out_iso = cfg_reg[`EP_OUT_ISO-`EP_OUT_ISO];
  assign in_iso = cfg_reg[`EP_IN_ISO-`EP_OUT_ISO];
  assign max_packet_size_field_bytes = {1'b0, max_packet_size_field_reg, 3'h0};

  // OUT token outcome; tokens of the wrong direction get no answer
  assign out_stall_ev = i_out_tok && !dir_in
    && (out_sdstall_reg || (i_out_cnt > max_packet_size_field_bytes));
  assign out_store = i_out_tok && !dir_in && !out_stall_ev && !out_rdy_reg;

  // IN token outcome
  assign in_stall_ev = i_in_tok && dir_in && in_sdstall_reg;
  assign in_send_ev = i_in_tok && dir_in && !in_sdstall_reg
    && (in_bus.cnt != 2'h0);
  assign under_ev = i_in_tok && dir_in && !in_sdstall_reg
    && (in_bus.cnt == 2'h0) && in_iso;

  // nak: non-iso OUT data while the last packet is still held, or non-iso IN with nothing held
  assign out_nak_ev = i_out_tok && !dir_in && !out_stall_ev && out_rdy_reg && !out_iso;
  assign in_nak_ev = i_in_tok && dir_in && !in_sdstall_reg
    && (in_bus.cnt == 2'h0) && !in_iso;

  // software request to mark a loaded packet ready
  assign sw_set_rdy = wr_csr && dir_in && i_wdata[`EP_IN_RDY]
    && !in_sdstall_reg && !in_bus.full;
  assign flush_go = (fl_state_reg == usbep_pkg::FL_WAIT) && !i_xact_busy;

  // toggle: cleared by the clear bit of the selected direction only, advanced on good data
  assign tog_clear = wr_csr && ((!dir_in && i_wdata[`EP_OUT_CLTOG])
    || (dir_in && i_wdata[`EP_IN_CLTOG]));
  assign tog_adv = (out_store && !out_iso) || (i_in_ack && dir_in && !in_iso);

  // packet tracker drive: an underrun swallows the next ready request
  assign in_bus.push = sw_set_rdy && !drop_next_reg;
  assign in_bus.pop = (i_in_ack && dir_in) || flush_go;
  assign in_bus.clr = in_stall_ev;
  assign in_bus.big = (max_packet_size_field_bytes > (`EP_FIFO_BYTES >> 1));

  // block from the edge at which the ready bit starts to read one, not a cycle later
  assign wr_block_next = dir_in && (in_bus.full
    || (in_bus.push && !in_bus.pop && (in_bus.big || (in_bus.cnt == 2'h1))));

  usbep_in_track u_track (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .trk(in_bus)
  );

  usbep_toggle u_toggle (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(tog_clear),
    .i_advance(tog_adv),
    .o_toggle(o_toggle)
  );

  // size field only moves when the same write carries the enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      max_packet_size_field_reg <= `EP_MAX_PACKET_SIZE_FIELD_RESET;
    end else if (wr_csr && i_wdata[`EP_MAX_PACKET_SIZE_FIELD_SET]) begin
      max_packet_size_field_reg <= i_wdata[`EP_MAX_PACKET_SIZE_FIELD_MSB:`EP_MAX_PACKET_SIZE_FIELD_LSB];
    end
  end

  // type, auto and direction bits are guarded by their own enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_reg <= `EP_CFG_RESET;
    end else if (wr_csr && i_wdata[`EP_CFG_SET]) begin
      cfg_reg <= i_wdata[`EP_IN_AUTO:`EP_OUT_ISO];
    end
  end

  // out packet ready: hardware set wins over software or auto clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_rdy_reg <= 1'b0;
    end else if (out_store) begin
      out_rdy_reg <= 1'b1;
    end else if (!dir_in && out_auto_clr()) begin
      out_rdy_reg <= 1'b0;
    end else if (wr_csr && !dir_in && !i_wdata[`EP_OUT_RDY]) begin
      out_rdy_reg <= 1'b0;
    end
  end

  function automatic logic out_auto_clr();
    out_auto_clr = cfg_reg[`EP_OUT_AUTO-`EP_OUT_ISO] && i_out_unloaded;
  endfunction

  // send-stall bits are plain read/write; kept until software clears them
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_sdstall_reg <= 1'b0;
      in_sdstall_reg <= 1'b0;
    end else if (wr_csr) begin
      out_sdstall_reg <= i_wdata[`EP_OUT_SDSTALL];
      in_sdstall_reg <= i_wdata[`EP_IN_SDSTALL];
    end
  end

  // sent-stall flags: writing zero clears, a stall in the same cycle wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_ststall_reg <= 1'b0;
    end else if (out_stall_ev) begin
      out_ststall_reg <= 1'b1;
    end else if (wr_csr && !i_wdata[`EP_OUT_STSTALL]) begin
      out_ststall_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_ststall_reg <= 1'b0;
    end else if (in_stall_ev) begin
      in_ststall_reg <= 1'b1;
    end else if (wr_csr && !i_wdata[`EP_IN_STSTALL]) begin
      in_ststall_reg <= 1'b0;
    end
  end

  // underrun flag, cleared by writing zero; set wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_under_reg <= 1'b0;
    end else if (under_ev) begin
      in_under_reg <= 1'b1;
    end else if (wr_csr && !i_wdata[`EP_IN_UNDER]) begin
      in_under_reg <= 1'b0;
    end
  end

  // remembers that the packet after an underrun is stale
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drop_next_reg <= 1'b0;
    end else if (under_ev) begin
      drop_next_reg <= 1'b1;
    end else if (sw_set_rdy) begin
      drop_next_reg <= 1'b0;
    end
  end

  // flush sequencer: request waits out a busy transaction
  always_comb begin
    fl_state_next = fl_state_reg;
    case (fl_state_reg)
      usbep_pkg::FL_IDLE: begin
        if (wr_csr && dir_in && i_wdata[`EP_IN_FLUSH]) begin
          fl_state_next = usbep_pkg::FL_WAIT;
        end
      end
      usbep_pkg::FL_WAIT: begin
        if (!i_xact_busy) begin
          fl_state_next = usbep_pkg::FL_IDLE;
        end
      end
      default: begin
        fl_state_next = usbep_pkg::FL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fl_state_reg <= usbep_pkg::FL_IDLE;
    end else begin
      fl_state_reg <= fl_state_next;
    end
  end

  // the flush bit mirrors a pending flush and drops when it completes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_flush_reg <= 1'b0;
    end else begin
      in_flush_reg <= (fl_state_next == usbep_pkg::FL_WAIT);
    end
  end

  // handshake answers toward the serial engine, one cycle after the token
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_stall <= 1'b0;
      o_ack <= 1'b0;
      o_nak <= 1'b0;
    end else begin
      o_stall <= out_stall_ev || in_stall_ev;
      o_ack <= out_store && !out_iso; // iso gets no ACK or NAK
      o_nak <= out_nak_ev || in_nak_ev;
    end
  end

  // IN data answers: a packet, or a zero-length one after underrun
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_in_send <= 1'b0;
      o_in_zlp <= 1'b0;
    end else begin
      o_in_send <= in_send_ev;
      o_in_zlp <= under_ev;
    end
  end

  // FIFO steering: flush, discard after underrun, software write block
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fifo_flush <= 1'b0;
      o_fifo_drop <= 1'b0;
      o_wr_block <= 1'b0;
    end else begin
      o_fifo_flush <= flush_go;
      o_fifo_drop <= sw_set_rdy && drop_next_reg;
      o_wr_block <= wr_block_next;
    end
  end

  // interrupt on delivery and on flush completion; a pulse, no status of its own
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_int <= 1'b0;
    end else begin
      o_int <= (i_in_ack && dir_in) || flush_go;
    end
  end

  // status word as software sees it; enables and toggle-clear bits always read zero
  always_comb begin
    csr_word = 32'h0000_0000;
    csr_word[`EP_MAX_PACKET_SIZE_FIELD_MSB:`EP_MAX_PACKET_SIZE_FIELD_LSB] = max_packet_size_field_reg;
    csr_word[`EP_IN_AUTO:`EP_OUT_ISO] = cfg_reg;
    csr_word[`EP_OUT_RDY] = out_rdy_reg;
    csr_word[`EP_OUT_SDSTALL] = out_sdstall_reg;
    csr_word[`EP_OUT_STSTALL] = out_ststall_reg;
    csr_word[`EP_IN_RDY] = in_bus.full;
    csr_word[`EP_IN_NEMP] = (in_bus.cnt != 2'h0);
    csr_word[`EP_IN_UNDER] = in_under_reg;
    csr_word[`EP_IN_FLUSH] = in_flush_reg;
    csr_word[`EP_IN_SDSTALL] = in_sdstall_reg;
    csr_word[`EP_IN_STSTALL] = in_ststall_reg;
  end

  // read data only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (rd_csr) begin
      o_rdata <= csr_word;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule

/* File: usbep_ep4_chk.sv */
/*
  Port checker for the endpoint 4 control block.
  Assumes it is bound to usbep_ep4_csr and sees only its ports.
*/
`timescale 1ns/1ps
module usbep_ep4_chk (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, low
  input wire logic i_out_tok, // OUT packet done
  input wire logic i_in_tok, // IN token
  input wire logic i_in_ack, // host ack
  input wire logic i_xact_busy, // transaction busy
  input wire logic o_stall, // stall pulse
  input wire logic o_ack, // ack pulse
  input wire logic o_in_send, // send pulse
  input wire logic o_in_zlp, // zero-length pulse
  input wire logic o_fifo_flush, // flush pulse
  input wire logic o_int // interrupt pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // every answer is one cycle late, so it needs a cause at the edge before
  a_ack_has_packet: assert property (o_ack |-> $past(i_out_tok)) else $error("ack without OUT packet");
  a_stall_has_token: assert property (o_stall |-> $past(i_out_tok || i_in_tok)) else $error("stray stall");
  a_send_has_token: assert property (o_in_send |-> $past(i_in_tok, 1)) else $error("send without IN token");
  // a flush must never cut into a running transaction
  a_flush_when_idle: assert property (o_fifo_flush |-> !$past(i_xact_busy)) else $error("flush while busy");
  a_int_has_cause: assert property (o_int |-> $past(i_in_ack) || o_fifo_flush) else $error("stray interrupt");
  a_zlp_on_token: assert property (o_in_zlp |-> $past(i_in_tok) && !o_in_send) else $error("bad zero-length");
  a_flush_raises_int: assert property (o_fifo_flush |-> o_int) else $error("flush without interrupt");
  a_stall_alone: assert property (o_stall |-> !(o_ack || o_in_send || o_in_zlp)) else $error("stall mixed");
endmodule

bind usbep_ep4_csr usbep_ep4_chk usbep_ep4_chk_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_out_tok(i_out_tok),
  .i_in_tok(i_in_tok), .i_in_ack(i_in_ack), .i_xact_busy(i_xact_busy), .o_stall(o_stall), .o_ack(o_ack),
  .o_in_send(o_in_send), .o_in_zlp(o_in_zlp), .o_fifo_flush(o_fifo_flush), .o_int(o_int));

/* File: usbep_host_model.sv */
/*
  Behavioural USB host: issues OUT packets and IN tokens as one-cycle pulses.
  Assumes the endpoint answers one cycle after each pulse.
*/
`timescale 1ns/1ps
module usbep_host_model (
  input wire logic i_clk, // clock
  output logic o_out_tok, // OUT packet pulse
  output logic [7:0] o_out_cnt, // OUT byte count
  output logic o_in_tok, // IN token pulse
  output logic o_in_ack, // ack of IN data
  output logic o_busy, // transaction busy
  input wire logic i_stall, // stall answer
  input wire logic i_ack, // ack answer
  input wire logic i_nak, // nak answer
  input wire logic i_send, // data sent
  input wire logic i_zlp, // zero-length sent
  input wire logic i_int // interrupt
);
  // idle lines at time zero
  initial begin
    o_out_tok = 1'b0;
    o_out_cnt = 8'h00;
    o_in_tok = 1'b0;
    o_in_ack = 1'b0;
    o_busy = 1'b0;
  end
  // one OUT packet; resp = {stall, ack, nak}
  task automatic out_pkt(input logic [7:0] cnt, output logic [2:0] resp);
    @(posedge i_clk);
    o_out_tok <= 1'b1;
    o_out_cnt <= cnt;
    o_busy <= 1'b1;
    @(posedge i_clk);
    o_out_tok <= 1'b0;
    o_out_cnt <= ~cnt; // count is stale now, so never leave it looking valid
    o_busy <= 1'b0;
    #1;
    resp = {i_stall, i_ack, i_nak};
  endtask
  // one IN transfer held busy for extra cycles; resp = {stall, nak, send, zlp}
  task automatic in_xfer(input int hold, output logic [3:0] resp, output logic irq);
    @(posedge i_clk);
    o_in_tok <= 1'b1;
    o_busy <= 1'b1;
    @(posedge i_clk);
    o_in_tok <= 1'b0;
    #1;
    resp = {i_stall, i_nak, i_send, i_zlp};
    repeat (hold) @(posedge i_clk);
    @(posedge i_clk);
    o_in_ack <= resp[1]; // a host acks only data it really got
    @(posedge i_clk);
    o_in_ack <= 1'b0;
    o_busy <= 1'b0;
    #1;
    irq = i_int;
  endtask
endmodule

/* File: usbep_ep4_csr_test.sv */
/*
  Self-checking bench for the endpoint 4 control block.
  Assumes the host model drives the token side and the bench the register port.
*/
`timescale 1ns/1ps
`include "usbep_map.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module usbep_ep4_csr_test;
  logic clk, rstn, wr_s, rd_s, unl, out_tok, in_tok, in_ack, busy;
  logic stall, ack, nak, snd, zlp, tog, fl, drop, blk, irq;
  logic [7:0] addr, out_cnt;
  logic [31:0] wdata, rdata;
  logic [2:0] ro;
  logic [3:0] ri;
  logic q;
  int n_mismatch = 0;
  int tests_run = 0;
  usbep_ep4_csr usbep_ep4_csr_inst (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_out_tok(out_tok), .i_out_cnt(out_cnt), .i_out_unloaded(unl),
    .i_in_tok(in_tok), .i_in_ack(in_ack), .i_xact_busy(busy), .o_stall(stall), .o_ack(ack), .o_nak(nak),
    .o_in_send(snd), .o_in_zlp(zlp), .o_toggle(tog), .o_fifo_flush(fl), .o_fifo_drop(drop),
    .o_wr_block(blk), .o_int(irq));
  usbep_host_model usbep_host_model_inst (.i_clk(clk), .o_out_tok(out_tok), .o_out_cnt(out_cnt),
    .o_in_tok(in_tok), .o_in_ack(in_ack), .o_busy(busy), .i_stall(stall), .i_ack(ack), .i_nak(nak),
    .i_send(snd), .i_zlp(zlp), .i_int(irq));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  // register read compared with an expected word; data stands one cycle only
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata)
  endtask
  task automatic t_reset;
    rdc(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_8082); // unmapped write must change nothing
    rdc(`EP_CSR_OFF, 32'(`EP_CFG_RESET) << 8);
  endtask
  task automatic t_out;
    wr(`EP_CSR_OFF, 32'h0000_8082);
    rdc(`EP_CSR_OFF, 32'h0000_0002);
    wr(`EP_CSR_OFF, 32'h0000_0405);
    rdc(`EP_CSR_OFF, 32'h0000_0002);
    usbep_host_model_inst.out_pkt(8'h10, ro);
    `CHK("out max", 3'b010, ro)
    `CHK("toggle adv", 1'b1, tog)
    rdc(`EP_CSR_OFF, 32'h0001_0002);
    wr(`EP_CSR_OFF, 32'h0080_0000);
    `CHK("toggle", 1'b0, tog)
    usbep_host_model_inst.out_pkt(8'h11, ro);
    `CHK("out over", 3'b100, ro)
    rdc(`EP_CSR_OFF, 32'h0040_0002);
    wr(`EP_CSR_OFF, 32'h0020_0000);
    usbep_host_model_inst.out_pkt(8'h08, ro);
    `CHK("out stall", 3'b100, ro)
    wr(`EP_CSR_OFF, 32'h0000_0000);
    usbep_host_model_inst.out_pkt(8'h08, ro);
    `CHK("stall off", 3'b010, ro)
    wr(`EP_CSR_OFF, 32'h0000_8200);
    usbep_host_model_inst.out_pkt(8'h08, ro);
    @(posedge clk);
    unl <= 1'b1;
    @(posedge clk);
    unl <= 1'b0;
    rdc(`EP_CSR_OFF, 32'h0000_0202);
    wr(`EP_CSR_OFF, 32'h0000_8100);
    usbep_host_model_inst.out_pkt(8'h08, ro);
    `CHK("iso out", 3'b000, ro)
    rdc(`EP_CSR_OFF, 32'h0001_0102);
  endtask
  task automatic t_in;
    wr(`EP_CSR_OFF, 32'h0000_8400);
    usbep_host_model_inst.out_pkt(8'h08, ro);
    `CHK("out in IN", 3'b000, ro)
    usbep_host_model_inst.in_xfer(0, ri, q);
    `CHK("in empty", 4'b0100, ri)
    wr(`EP_CSR_OFF, 32'h0100_0000);
    rdc(`EP_CSR_OFF, 32'h0200_0402);
    `CHK("block", 1'b0, blk)
    wr(`EP_CSR_OFF, 32'h0100_0000);
    rdc(`EP_CSR_OFF, 32'h0300_0402);
    `CHK("block", 1'b1, blk)
    usbep_host_model_inst.in_xfer(0, ri, q);
    `CHK("in send", 4'b0010, ri)
    `CHK("in irq", 1'b1, q)
    `CHK("toggle", 1'b1, tog)
    rdc(`EP_CSR_OFF, 32'h0200_0402);
    wr(`EP_CSR_OFF, 32'h4000_0000);
    `CHK("toggle", 1'b0, tog)
    wr(`EP_CSR_OFF, 32'h0100_0000);
    wr(`EP_CSR_OFF, 32'h0800_0000);
    // bounded wait for the flush pulse
    repeat (20) begin
      if (fl !== 1'b1) begin
        @(posedge clk);
        #1;
      end
    end
    `CHK("flush irq", 2'b11, {fl, irq})
    rdc(`EP_CSR_OFF, 32'h0200_0402);
    wr(`EP_CSR_OFF, 32'h0100_0000);
    // flush requested in mid-transfer must wait for it
    fork
      usbep_host_model_inst.in_xfer(4, ri, q);
      begin
        repeat (2) @(posedge clk);
        wr(`EP_CSR_OFF, 32'h0800_0000);
        rdc(`EP_CSR_OFF, 32'h0B00_0402);
      end
    join
    repeat (3) @(posedge clk);
    rdc(`EP_CSR_OFF, 32'h0000_0402);
    wr(`EP_CSR_OFF, 32'h0100_0000);
    wr(`EP_CSR_OFF, 32'h1000_0000);
    wr(`EP_CSR_OFF, 32'h1100_0000);
    rdc(`EP_CSR_OFF, 32'h1200_0402);
    usbep_host_model_inst.in_xfer(0, ri, q);
    `CHK("in stall", 4'b1000, ri)
    rdc(`EP_CSR_OFF, 32'h3000_0402);
    wr(`EP_CSR_OFF, 32'h0000_0000);
    usbep_host_model_inst.in_xfer(0, ri, q);
    `CHK("stall off", 4'b0100, ri)
  endtask
  task automatic t_iso;
    wr(`EP_CSR_OFF, 32'h0000_8C00);
    usbep_host_model_inst.in_xfer(0, ri, q);
    `CHK("zlp", 4'b0001, ri)
    rdc(`EP_CSR_OFF, 32'h0400_0C02);
    wr(`EP_CSR_OFF, 32'h0500_0000);
    `CHK("drop", 1'b1, drop)
    rdc(`EP_CSR_OFF, 32'h0400_0C02);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    unl = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_iso();
    give_verdict();
  end
  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #(100 * 5000);
    n_mismatch++;
    give_verdict();
  end
endmodule
